/* File: design/tle_port_logic.sv */
// framer-side digital logic of one t1/e1 line interface port
// Function
// - bipolar mode: framer pos/neg transmit halves go onto the line
// - tristate/mode pin toggled by master clock selects unipolar framer interface
// - rx negative/positive outputs follow negative/positive received line pulses
// - receive outputs are nrz; edge select picks their valid clock edge
// - normally the receive clock is the clock recovered from the line
// - on loss of signal the receive clock comes from master clock
// - each serial clock cycle shifts one bit of the selected port
// - function select makes pin violation input, fast clock, or qrss control
// - violation input sampled on transmit clock falling edge
// - sampled high gives one violation at next mark; low-high for more
// - inserted violations never corrupt zero-substitution code words
// - clock function outputs eight-times clock from jitter-attenuated clock
// - without jitter-attenuated clock the fast clock follows recovery clock
// - qrss function high enables detector and transmits qrss pattern
// - qrss: each low-high of positive data at mclk fall inserts one error
// - interrupt output pulled low when port state changed
// - interrupt output is open drain: pull low or release only
// - framer transmit data sampled on falling edge of transmit clock
// - mode pin high tristates outputs; low gives bipolar, encoders off
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module tle_port_logic
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        tx_clock,
    input  wire logic        master_clock,
    input  wire logic        tx_positive_data,
    input  wire logic        tx_negative_data,
    input  wire logic        tristate_mode_control,
    input  wire logic [1:0]  multi_function_select,
    input  wire logic        multi_function_port_pin_in,
    output logic             multi_function_port_pin_out,
    output logic             multi_function_port_pin_oe_n,
    output logic             rx_positive_data,
    output logic             rx_negative_data,
    output logic             rx_recovered_clock,
    output logic             outputs_oe_n,
    input  wire logic        serial_clock,
    input  wire logic        serial_port_select_n,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             line_tx_pos,
    output logic             line_tx_neg,
    input  wire logic        line_rx_pos,
    input  wire logic        line_rx_neg,
    input  wire logic        line_rx_clock,
    input  wire logic        line_los,
    input  wire logic        jitter_attenuator_clock_8x,
    input  wire logic        jitter_attenuator_valid,
    input  wire logic        recovery_clock_8x,
    output logic             port_a_irq_n_out,
    output logic             port_a_irq_n_oe_n
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int TOG_W = $clog2(tle_pkg::TOGGLE_HOLD + 1);
    localparam int WIN_W = $clog2(tle_pkg::QRSS_WINDOW);
    localparam int SUB_W = $clog2(tle_pkg::SUBST_SPAN + 1);

    logic        tx_clock_r, mclk_r, lclk_r, sclk_r, tsm_r;
    logic [TOG_W-1:0] tog_cnt_r, tog_cnt_nxt;
    tle_pkg::tle_mode_t mode_r, mode_nxt;
    logic        edge_sel_r, edge_sel_nxt;
    logic        viol_pend_r, viol_pend_nxt;
    logic        err_pend_r, err_pend_nxt;
    logic        last_pol_r, last_pol_nxt;
    logic [SUB_W-1:0] guard_r, guard_nxt;
    logic [19:0] prbs_r, prbs_nxt;
    logic [19:0] det_r, det_nxt;
    logic [WIN_W-1:0] win_cnt_r, win_cnt_nxt;
    logic [2:0]  err_cnt_r, err_cnt_nxt;
    logic        qsync_r, qsync_nxt;
    logic        irq_r, irq_nxt;
    logic [tle_pkg::SHIFT_WIDTH-1:0] shift_r, shift_nxt;
    logic        txp_nxt, txn_nxt, rxp_nxt, rxn_nxt, rclk_nxt;
    logic        mfp_out_nxt, mfp_oe_n_nxt, oe_n_nxt, sdo_nxt;
    logic [31:0] rdata_nxt;

    // ------------------------------------------------------------
    // edge events of sampled clock inputs
    // ------------------------------------------------------------
    logic tx_clock_fall, mclk_fall, lclk_rise, lclk_fall, sclk_rise;
    logic tsm_change, los_change_r, qrss_on, fn_viol, fn_clock;
    tle_pkg::tle_func_t func;

    assign tx_clock_fall  = tx_clock_r & ~tx_clock;
    assign mclk_fall  = mclk_r & ~master_clock;
    assign lclk_rise  = ~lclk_r & line_rx_clock;
    assign lclk_fall  = lclk_r & ~line_rx_clock;
    assign sclk_rise  = ~sclk_r & serial_clock;
    assign tsm_change = tsm_r ^ tristate_mode_control;
    assign func       = tle_pkg::tle_func_t'(multi_function_select);
    assign fn_viol    = (func == tle_pkg::TLE_FN_VIOLATION) || (func == tle_pkg::TLE_FN_SPARE);
    assign fn_clock   = (func == tle_pkg::TLE_FN_CLOCK);
    assign qrss_on    = (func == tle_pkg::TLE_FN_QRSS) && multi_function_port_pin_in;

    // ------------------------------------------------------------
    // insert edge detectors
    // ------------------------------------------------------------
    tle_edge_if viol_bus ();
    tle_edge_if err_bus ();

    // violation pin sampled at transmit clock fall
    assign viol_bus.sample_fall = tx_clock_fall & fn_viol;
    assign viol_bus.level       = multi_function_port_pin_in;
    // positive data sampled at master clock fall
    assign err_bus.sample_fall  = mclk_fall & qrss_on;
    assign err_bus.level        = tx_positive_data;

    tle_edge_insert u_viol_edge
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .edge_bus (viol_bus.detector)
    );

    tle_edge_insert u_err_edge
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .edge_bus (err_bus.detector)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic mark;
        logic pol;
        logic src_viol;
        logic rbit;
        logic rx_edge;
        mark     = 1'b0;
        pol      = 1'b0;
        src_viol = 1'b0;
        rbit     = line_rx_pos | line_rx_neg;
        rx_edge  = 1'b0;

        // static pin level vs. master clock toggling
        tog_cnt_nxt = tog_cnt_r;
        if (tsm_change)
            tog_cnt_nxt = '0;
        else if (mclk_fall && (tog_cnt_r != TOG_W'(tle_pkg::TOGGLE_HOLD)))
            tog_cnt_nxt = tog_cnt_r + 1'b1;
        // static high tristates, static low is bipolar
        if (tog_cnt_r != TOG_W'(tle_pkg::TOGGLE_HOLD))
            mode_nxt = tle_pkg::TLE_MODE_UNIPOLAR;
        else if (tristate_mode_control)
            mode_nxt = tle_pkg::TLE_MODE_TRISTATE;
        else
            mode_nxt = tle_pkg::TLE_MODE_BIPOLAR;

        // one pending violation, new request needs a fresh edge
        viol_pend_nxt = viol_pend_r;
        err_pend_nxt  = err_pend_r & qrss_on;
        last_pol_nxt  = last_pol_r;
        guard_nxt     = guard_r;
        prbs_nxt      = prbs_r;
        txp_nxt       = line_tx_pos;
        txn_nxt       = line_tx_neg;

        // transmit step on transmit clock fall
        if (tx_clock_fall)
        begin
            if (qrss_on)
            begin
                // pattern generator, error flips one bit
                mark         = prbs_r[19] ^ err_pend_r;
                pol          = ~last_pol_r;
                prbs_nxt     = {prbs_r[18:0], prbs_r[19] ^ prbs_r[tle_pkg::PRBS_TAP - 1]};
                err_pend_nxt = 1'b0;
            end
            else if (mode_r == tle_pkg::TLE_MODE_UNIPOLAR)
            begin
                mark = tx_positive_data;
                pol  = ~last_pol_r;
            end
            else
            begin
                // framer halves drive the line pair
                mark     = tx_positive_data | tx_negative_data;
                pol      = tx_positive_data;
                src_viol = mark & (pol == last_pol_r);
            end
            // guard bits of a substitution code word
            if (src_viol)
                guard_nxt = SUB_W'(tle_pkg::SUBST_SPAN);
            else if (guard_r != '0)
                guard_nxt = guard_r - 1'b1;
            // violation repeats the previous mark polarity
            if (viol_pend_r && mark && (guard_r == '0) && !src_viol)
            begin
                pol           = last_pol_r;
                viol_pend_nxt = 1'b0;
            end
            if (mark)
                last_pol_nxt = pol;
            txp_nxt = mark & pol;
            txn_nxt = mark & ~pol;
        end
        // request set wins over consumption
        if (viol_bus.insert_pulse)
            viol_pend_nxt = 1'b1;
        if (err_bus.insert_pulse)
            err_pend_nxt = 1'b1;

        // outputs change on the edge opposite the valid edge
        rx_edge = edge_sel_r ? lclk_fall : lclk_rise;
        rxp_nxt = rx_positive_data;
        rxn_nxt = rx_negative_data;
        det_nxt     = det_r;
        win_cnt_nxt = win_cnt_r;
        err_cnt_nxt = err_cnt_r;
        qsync_nxt   = qsync_r & qrss_on;
        if (rx_edge)
        begin
            // line pulse polarity to nrz outputs
            rxp_nxt = line_rx_pos;
            rxn_nxt = line_rx_neg;
            if (qrss_on)
            begin
                det_nxt     = {det_r[18:0], rbit};
                win_cnt_nxt = win_cnt_r + 1'b1;
                if ((rbit != (det_r[19] ^ det_r[tle_pkg::PRBS_TAP - 1])) && (err_cnt_r != 3'h7))
                    err_cnt_nxt = err_cnt_r + 1'b1;
                if (win_cnt_r == WIN_W'(tle_pkg::QRSS_WINDOW - 1))
                begin
                    qsync_nxt   = (err_cnt_nxt < 3'(tle_pkg::QRSS_ERR_LIMIT));
                    err_cnt_nxt = 3'h0;
                end
            end
        end
        // recovered clock, master clock under loss of signal
        rclk_nxt = line_los ? master_clock : line_rx_clock;

        // fast clock source on the multi-function pin
        mfp_out_nxt  = jitter_attenuator_valid ? jitter_attenuator_clock_8x : recovery_clock_8x;
        mfp_oe_n_nxt = ~(fn_clock && (mode_r != tle_pkg::TLE_MODE_TRISTATE));
        oe_n_nxt     = (mode_r == tle_pkg::TLE_MODE_TRISTATE);

        shift_nxt = shift_r;
        sdo_nxt   = serial_data_out;
        if (sclk_rise && !serial_port_select_n)
        begin
            shift_nxt = {shift_r[tle_pkg::SHIFT_WIDTH-2:0], serial_data_in};
            sdo_nxt   = shift_r[tle_pkg::SHIFT_WIDTH-2];
        end

        // register writes
        edge_sel_nxt = edge_sel_r;
        irq_nxt      = irq_r;
        if (reg_wr && (reg_addr == tle_pkg::OFS_CTRL))
            edge_sel_nxt = reg_wdata[tle_pkg::CTRL_EDGE_BIT];
        if (reg_wr && (reg_addr == tle_pkg::OFS_STATUS) && reg_wdata[tle_pkg::ST_IRQ_BIT])
            irq_nxt = 1'b0;
        // state change flags the host, set beats clear
        if (los_change_r || (qsync_nxt != qsync_r) || (mode_nxt != mode_r))
            irq_nxt = 1'b1;

        // read data only in the cycle after the strobe
        rdata_nxt = 32'h0000_0000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                tle_pkg::OFS_CTRL:
                    rdata_nxt[tle_pkg::CTRL_EDGE_BIT] = edge_sel_r;
                tle_pkg::OFS_STATUS:
                begin
                    rdata_nxt[tle_pkg::ST_LOS_BIT]      = line_los;
                    rdata_nxt[tle_pkg::ST_TRI_BIT]      = (mode_r == tle_pkg::TLE_MODE_TRISTATE);
                    rdata_nxt[tle_pkg::ST_UNIPOLAR_BIT] = (mode_r == tle_pkg::TLE_MODE_UNIPOLAR);
                    rdata_nxt[tle_pkg::ST_QRSS_ON_BIT]  = qrss_on;
                    rdata_nxt[tle_pkg::ST_QRSS_SYNC]    = qsync_r;
                    rdata_nxt[tle_pkg::ST_IRQ_BIT]      = irq_r;
                end
                tle_pkg::OFS_SHIFT:
                    rdata_nxt[tle_pkg::SHIFT_WIDTH-1:0] = shift_r;
                default:
                    rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic los_r;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_clock_r       <= 1'b0;
            mclk_r       <= 1'b0;
            lclk_r       <= 1'b1;   // no false rise on the first clock
            sclk_r       <= 1'b1;   // no false shift on the first clock
            tsm_r        <= 1'b0;
            los_r        <= 1'b0;
            los_change_r <= 1'b0;
            tog_cnt_r    <= TOG_W'(tle_pkg::TOGGLE_HOLD);
            mode_r       <= tle_pkg::TLE_MODE_BIPOLAR;
            edge_sel_r   <= tle_pkg::CTRL_RESET[tle_pkg::CTRL_EDGE_BIT];
            viol_pend_r  <= 1'b0;
            err_pend_r   <= 1'b0;
            last_pol_r   <= 1'b0;
            guard_r      <= '0;
            prbs_r       <= tle_pkg::PRBS_SEED;
            det_r        <= '0;
            win_cnt_r    <= '0;
            err_cnt_r    <= 3'h0;
            qsync_r      <= 1'b0;
            irq_r        <= 1'b0;
            shift_r      <= '0;
            line_tx_pos  <= 1'b0;
            line_tx_neg  <= 1'b0;
            rx_positive_data   <= 1'b0;
            rx_negative_data   <= 1'b0;
            rx_recovered_clock <= 1'b0;
            multi_function_port_pin_out  <= 1'b0;
            multi_function_port_pin_oe_n <= 1'b1;
            outputs_oe_n       <= 1'b0;
            serial_data_out    <= 1'b0;
            reg_rdata          <= 32'h0000_0000;
            port_a_irq_n_oe_n  <= 1'b1;
            port_a_irq_n_out   <= 1'b0;
        end
        else
        begin
            tx_clock_r       <= tx_clock;
            mclk_r       <= master_clock;
            lclk_r       <= line_rx_clock;
            sclk_r       <= serial_clock;
            tsm_r        <= tristate_mode_control;
            los_r        <= line_los;
            los_change_r <= los_r ^ line_los;
            tog_cnt_r    <= tog_cnt_nxt;
            mode_r       <= mode_nxt;
            edge_sel_r   <= edge_sel_nxt;
            viol_pend_r  <= viol_pend_nxt;
            err_pend_r   <= err_pend_nxt;
            last_pol_r   <= last_pol_nxt;
            guard_r      <= guard_nxt;
            prbs_r       <= prbs_nxt;
            det_r        <= det_nxt;
            win_cnt_r    <= win_cnt_nxt;
            err_cnt_r    <= err_cnt_nxt;
            qsync_r      <= qsync_nxt;
            irq_r        <= irq_nxt;
            shift_r      <= shift_nxt;
            line_tx_pos  <= txp_nxt;
            line_tx_neg  <= txn_nxt;
            rx_positive_data   <= rxp_nxt;
            rx_negative_data   <= rxn_nxt;
            rx_recovered_clock <= rclk_nxt;
            multi_function_port_pin_out  <= mfp_out_nxt;
            multi_function_port_pin_oe_n <= mfp_oe_n_nxt;
            outputs_oe_n       <= oe_n_nxt;
            serial_data_out    <= sdo_nxt;
            reg_rdata          <= rdata_nxt;
            // release when idle, pull low when pending, never drive high
            port_a_irq_n_oe_n  <= ~irq_nxt;
            port_a_irq_n_out   <= 1'b0;
        end
    end

endmodule : tle_port_logic

/* File: design/tle_pkg.sv */
// shared constants for the t1/e1 port framer-side logic
package tle_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_SHIFT  = 4'h8;

    // ctrl fields
    localparam int CTRL_EDGE_BIT = 0;      // rx clock edge select
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status fields
    localparam int ST_LOS_BIT      = 0;
    localparam int ST_TRI_BIT      = 1;
    localparam int ST_UNIPOLAR_BIT = 2;
    localparam int ST_QRSS_ON_BIT  = 3;
    localparam int ST_QRSS_SYNC    = 4;
    localparam int ST_IRQ_BIT      = 5;    // write one to clear

    // ----------------------------------------------------------------
    // multi-function pin selections
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TLE_FN_VIOLATION = 2'h0,
        TLE_FN_CLOCK     = 2'h1,
        TLE_FN_QRSS      = 2'h2,
        TLE_FN_SPARE     = 2'h3
    } tle_func_t;

    typedef enum logic [1:0] {
        TLE_MODE_BIPOLAR,
        TLE_MODE_UNIPOLAR,
        TLE_MODE_TRISTATE
    } tle_mode_t;

    // ----------------------------------------------------------------
    // timing and sizes
    // ----------------------------------------------------------------
    localparam int HF_CLK_T1_KHZ   = 12352;  // eight-times rate, t1
    localparam int HF_CLK_E1_KHZ   = 16384;  // eight-times rate, e1
    localparam int MCLK_T1_KHZ     = 1544;
    localparam int MCLK_E1_KHZ     = 2048;
    localparam int TOGGLE_HOLD     = 4;      // mclk falls without toggle -> static
    localparam int SUBST_SPAN      = 8;      // bits guarded after a code word
    localparam int PRBS_LEN        = 20;
    localparam int PRBS_TAP        = 17;
    localparam logic [19:0] PRBS_SEED = 20'hF_FFFF;
    localparam int QRSS_WINDOW     = 128;
    localparam int QRSS_ERR_LIMIT  = 4;      // sync while fewer errors in window
    localparam int SHIFT_WIDTH     = 16;

endpackage : tle_pkg

/* File: design/tle_edge_if.sv */
// carrier between a sampled-level source and its transition detector
`timescale 1ns/1ns
interface tle_edge_if;
    logic sample_fall;   // one-cycle: falling edge of the sampling clock
    logic level;         // pin level being sampled
    logic insert_pulse;  // one-cycle request per low-to-high transition

    modport source
    (
        output sample_fall,
        output level,
        input  insert_pulse
    );
    modport detector
    (
        input  sample_fall,
        input  level,
        output insert_pulse
    );
endinterface : tle_edge_if

/* File: design/tle_edge_insert.sv */
// low-to-high transition detector on a sampled insert input
`timescale 1ns/1ns
module tle_edge_insert
(
    input  wire logic           clk_sys,
    input  wire logic           rst_n,
    tle_edge_if.detector        edge_bus
);

    logic prev_r;
    logic prev_nxt;
    logic pulse_r;
    logic pulse_nxt;

    // ------------------------------------------------------------
    // previous-sample comparison
    // ------------------------------------------------------------
    // one request per rising transition
    always_comb
    begin
        prev_nxt  = prev_r;
        pulse_nxt = 1'b0;
        if (edge_bus.sample_fall)
        begin
            prev_nxt  = edge_bus.level;
            pulse_nxt = edge_bus.level & ~prev_r;
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_r  <= 1'b1;   // level high at reset is not an edge
            pulse_r <= 1'b0;
        end
        else
        begin
            prev_r  <= prev_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign edge_bus.insert_pulse = pulse_r;

endmodule : tle_edge_insert

/* File: verification/tle_port_assertions.sv */
// concurrent checks on the port logic pins
`timescale 1ns/1ns
module tle_port_assertions
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        tx_clock,
    input wire logic        master_clock,
    input wire logic        tristate_mode_control,
    input wire logic [1:0]  multi_function_select,
    input wire logic        multi_function_port_pin_oe_n,
    input wire logic        rx_positive_data,
    input wire logic        rx_negative_data,
    input wire logic        rx_recovered_clock,
    input wire logic        outputs_oe_n,
    input wire logic        serial_clock,
    input wire logic        serial_port_select_n,
    input wire logic        serial_data_out,
    input wire logic        line_tx_pos,
    input wire logic        line_rx_pos,
    input wire logic        line_rx_neg,
    input wire logic        line_rx_clock,
    input wire logic        line_los,
    input wire logic        port_a_irq_n_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [2:0] up_r;
    wire        rclk_src = line_los ? master_clock : line_rx_clock;
    // live once the internal reset copy has gone
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            up_r <= 3'h0;
        else
            up_r <= {up_r[1:0], 1'b1};
    rd_idle_a: assert property (up_r[2] && !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    rclk_src_a: assert property (up_r[2] |-> rx_recovered_clock == $past(rclk_src))
        else $error("receive clock from wrong source");
    irq_drive_a: assert property (port_a_irq_n_out == 1'b0)
        else $error("interrupt pin driven high");
    tri_hold_a: assert property ($rose(outputs_oe_n) |-> $past(tristate_mode_control, 2))
        else $error("outputs released without mode pin high");
    pin_drive_a: assert property (!multi_function_port_pin_oe_n |-> $past(multi_function_select) == 2'h1)
        else $error("pin driven outside clock function");
    rx_edge_a: assert property (up_r[2] && $changed({rx_positive_data, rx_negative_data})
        |-> $past(line_rx_clock) != $past(line_rx_clock, 2) && rx_positive_data == $past(line_rx_pos)
        && rx_negative_data == $past(line_rx_neg))
        else $error("receive data moved off a line clock edge");
    tx_fall_a: assert property (up_r[2] && $changed(line_tx_pos) && $past(multi_function_select) != 2'h2
        |-> $past(tx_clock, 2) && !$past(tx_clock))
        else $error("line data moved off a tx clock fall");
    shift_step_a: assert property (up_r[2] && $changed(serial_data_out)
        |-> $past(serial_clock) && !$past(serial_clock, 2) && !$past(serial_port_select_n))
        else $error("serial out moved without a selected clock rise");
endmodule : tle_port_assertions
bind tle_port_logic tle_port_assertions u_chk (.*);

/* File: verification/tle_framer_model.sv */
// framer stand-in: transmit clock, master clock, bipolar data
`timescale 1ns/1ns
module tle_framer_model
(
    input  wire logic clk_sys,
    input  wire logic qrss_hold,
    output logic      tx_clock,
    output logic      master_clock,
    output logic      tx_positive_data,
    output logic      tx_negative_data
);
    int t_r = 0;
    // free cycle counter
    always @(posedge clk_sys)
        t_r <= t_r + 1;
    assign master_clock = (t_r % 14) < 7;
    assign tx_clock = (t_r % 12) < 6;
    // alternating marks, moved on the clock rise
    assign tx_negative_data = (t_r / 12) % 4 == 2;
    // positive data held low in qrss
    assign tx_positive_data = !qrss_hold && (t_r / 12) % 4 == 0;
endmodule : tle_framer_model

/* File: verification/testbench.sv */
// self-checking bench for the port logic
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench;
    typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} tle_row_t;
    logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, line_los = 1'b0;
    logic mfp_drv = 1'b0, ser_on = 1'b0, jitter_attenuator_valid = 1'b0, qrss_hold = 1'b0;
    logic lp = 1'b0, ln = 1'b0, rq = 1'b0;
    logic [1:0] multi_function_select = 2'h0, tri_sel = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] cnt = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, rd_v;
    wire [31:0] reg_rdata;
    wire [7:0] cd = cnt + 8'h02;
    wire tx_clock, master_clock, tx_positive_data, tx_negative_data, multi_function_port_pin_out;
    wire rx_positive_data, rx_negative_data, rx_recovered_clock, outputs_oe_n, serial_data_out;
    wire line_tx_pos, line_tx_neg, port_a_irq_n_out, port_a_irq_n_oe_n, multi_function_port_pin_oe_n;
    wire multi_function_port_pin_in = multi_function_port_pin_oe_n ? mfp_drv : multi_function_port_pin_out;
    wire irq_wire = port_a_irq_n_oe_n ? 1'b1 : port_a_irq_n_out;
    wire tristate_mode_control = tri_sel[1] ? master_clock : tri_sel[0];
    wire serial_clock = ser_on & cnt[3];
    wire serial_port_select_n = !ser_on;
    wire serial_data_in = 1'b1;
    wire line_rx_clock = cnt[2];
    wire line_rx_pos = cd[4:3] == 2'b01;
    wire line_rx_neg = cd[4:3] == 2'b11;
    wire jitter_attenuator_clock_8x = cnt[0];
    wire recovery_clock_8x = cnt[1];
    int n_errors = 0, tests_run = 0, n_viol = 0, n_mark = 0, v0;
    tle_row_t rows [3] = '{'{tle_pkg::OFS_CTRL, 32'h0000_0001, 32'h0000_0001},
        '{4'hC, 32'hFFFF_FFFF, 32'h0000_0000}, '{tle_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0000}};
    tle_port_logic DUT (.*);
    tle_framer_model u_framer (.*);
    always #25 clk_sys = !clk_sys;
    // line monitor, counts positive marks and marks flipped against the framer's data
    always @(posedge clk_sys)
    begin
        cnt <= cnt + 8'h01;
        lp <= line_tx_pos;
        ln <= line_tx_neg;
        rq <= recovery_clock_8x;
        n_mark <= n_mark + int'(line_tx_pos && !lp);
        n_viol <= n_viol + int'((line_tx_pos && !lp && tx_negative_data) || (line_tx_neg && !ln && tx_positive_data));
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask : rd
    task automatic print_verdict();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        cyc(5);
        `CHK(irq_wire, 1'b1)
        arst_n <= 1'b1;
        cyc(4);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            `CHK(rd_v, rows[i].e)
        end
        line_los <= 1'b1;
        cyc(8);
        `CHK(irq_wire, 1'b0)
        rd(tle_pkg::OFS_STATUS);
        `CHK(rd_v, 32'h0000_0021)
        wr(tle_pkg::OFS_STATUS, 32'h0000_0020);
        cyc(3);
        `CHK(irq_wire, 1'b1)
        tri_sel <= 2'h1;
        cyc(100);
        `CHK(outputs_oe_n, 1'b1)
        tri_sel <= 2'h2;
        cyc(100);
        rd(tle_pkg::OFS_STATUS);
        `CHK(rd_v[2], 1'b1)
        tri_sel <= 2'h0;
        line_los <= 1'b0;
        cyc(100);
        `CHK(outputs_oe_n, 1'b0)
        v0 = n_viol;
        cyc(200);
        `CHK(n_viol - v0, 0)
        `CHK(n_mark > 2, 1'b1)
        mfp_drv <= 1'b1;
        cyc(400);
        `CHK(n_viol - v0, 1)
        mfp_drv <= 1'b0;
        cyc(30);
        mfp_drv <= 1'b1;
        cyc(400);
        `CHK(n_viol - v0, 2)
        multi_function_select <= 2'h1;
        jitter_attenuator_valid <= 1'b1;
        cyc(8);
        `CHK(multi_function_port_pin_oe_n, 1'b0)
        `CHK(multi_function_port_pin_out, !jitter_attenuator_clock_8x)
        jitter_attenuator_valid <= 1'b0;
        cyc(8);
        `CHK(multi_function_port_pin_out, rq)
        multi_function_select <= 2'h2;
        qrss_hold <= 1'b1;
        cyc(50);
        rd(tle_pkg::OFS_STATUS);
        `CHK(rd_v[3], 1'b1)
        ser_on <= 1'b1;
        cyc(300);
        ser_on <= 1'b0;
        rd(tle_pkg::OFS_SHIFT);
        `CHK(rd_v, 32'h0000_FFFF)
        print_verdict();
    end
endmodule : testbench
